// >>> design/pp1_pkg.sv
package pp1_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses on the APB)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_DIR = 8'h04;
	localparam logic [7:0] ADDR_PULLUP = 8'h08;
	localparam logic [7:0] ADDR_FUNC = 8'h0c;
	localparam logic [7:0] ADDR_EDGE = 8'h10;
	localparam logic [7:0] ADDR_PMODE = 8'h14;
	localparam logic [7:0] ADDR_FLAGS = 8'h18;

	// ----------------------------------------------------------------
	// Field layouts and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] PIN_MASK = 8'hf1;
	localparam logic [7:0] FUNC_FIXED_ONE = 8'h04;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] PULLUP_RESET = 8'h00;
	localparam logic [7:0] FUNC_RESET = 8'h04;
	localparam logic [7:0] DIR_READ_VALUE = 8'hff;
	localparam int BIT_TRIG = 7;
	localparam int BIT_INT_B = 6;
	localparam int BIT_INT_A = 5;
	localparam int BIT_PWM = 4;
	localparam int BIT_CLKOUT = 0;

	// Edge select codes: 2'h3 (both edges) only acts on the trigger input.
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [5:0] EDGE_RESET = 6'h00;

	// Power modes.
	typedef enum logic [2:0] {
		PM_ACTIVE,
		PM_SUBACTIVE,
		PM_SLEEP,
		PM_SUBSLEEP,
		PM_WATCH,
		PM_STANDBY
	} pp1_pmode_t;

endpackage : pp1_pkg

// >>> design/pp1_edge_det.sv
`timescale 1ns/1ns
module pp1_edge_det import pp1_pkg::*; (
	input wire logic sys_clk, // System clock.
	input wire logic reset, // Synchronous reset.
	input wire logic enable, // Pin routed to this input.
	input wire logic level, // Pin level.
	input wire logic [1:0] sel, // Edge select.
	input wire logic allow_both, // Both-edge option present.
	output logic hit_ff // One-cycle edge pulse.
);
	logic prev_ff;
	logic rise;
	logic fall;

	assign rise = level & ~prev_ff;
	assign fall = ~level & prev_ff;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prev_ff <= 1'b0;
		end else begin
			prev_ff <= level;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			hit_ff <= 1'b0;
		end else if (!enable) begin
			hit_ff <= 1'b0;
		end else if (allow_both && sel == EDGE_BOTH) begin
			hit_ff <= rise | fall;
		end else if (sel[0] == EDGE_RISE[0]) begin
			hit_ff <= rise;
		end else begin
			hit_ff <= fall;
		end
	end
endmodule : pp1_edge_det

// >>> design/pp1_pin_cell.sv
`timescale 1ns/1ns
module pp1_pin_cell import pp1_pkg::*; (
	input wire logic sys_clk, // System clock.
	input wire logic reset, // Synchronous reset.
	input wire logic [2:0] pmode, // Power mode.
	input wire logic func_sel, // Alternate function selected.
	input wire logic func_is_out, // Alternate function drives pin.
	input wire logic func_val, // Alternate output value.
	input wire logic dir, // Direction bit.
	input wire logic data, // Stored output data.
	input wire logic pull, // Pull-up control bit.
	output logic oe_ff, // Pin output enable.
	output logic out_ff, // Pin output value.
	output logic pu_ff // Pull-up on.
);
	logic drive;
	logic pu_on;

	// With the function selected the direction bit plays no part.
	assign drive = func_sel ? func_is_out : dir;
	assign pu_on = pull & ~dir & ~func_sel;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			oe_ff <= 1'b0;
			out_ff <= 1'b0;
			pu_ff <= 1'b0;
		end else begin
			case (pp1_pmode_t'(pmode))
			PM_ACTIVE, PM_SUBACTIVE: begin
				oe_ff <= drive;
				out_ff <= func_sel ? func_val : data;
				pu_ff <= pu_on;
			end
			PM_SLEEP, PM_SUBSLEEP, PM_WATCH: begin
				// Outputs freeze so a pin keeps its level while clocks stop.
				oe_ff <= oe_ff;
				out_ff <= out_ff;
				pu_ff <= pu_ff;
			end
			PM_STANDBY: begin
				oe_ff <= 1'b0;
				out_ff <= 1'b0;
				pu_ff <= pu_on;
			end
			default: begin
				oe_ff <= 1'b0;
				out_ff <= 1'b0;
				pu_ff <= 1'b0;
			end
			endcase
		end
	end
endmodule : pp1_pin_cell

// >>> design/pp1_port.sv
// Behaviour
// - Input pin pull-up follows its control bit; the design holds it off while the pin's function is selected.
// - Pull-up bits 7..4,0 writable; 3..1 read zero.
// - Pull-up register resets to zero.
// - Function register resets to 0x04.
// - Function register bit 2 reads one.
// - Function register bits 3,1 read zero.
// - Bit 7 selects interrupt C / trigger input.
// - Bit 6 selects interrupt B input.
// - Bit 5 selects interrupt A input.
// - Bit 4 drives PWM output onto pin.
// - Bit 0 drives clock-divider output onto pin.
// - Function select overrides direction bit.
// - Edge select rise/fall; trigger also both.
// - Pin states per reset and power mode.
// - Direction bit one output, zero input.
// - Port read: data if output, else pin.
// - Output pins never enable pull-up.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ns
module pp1_port import pp1_pkg::*; (
	input wire logic sys_clk, // System clock, 125 MHz.
	input wire logic reset, // Synchronous reset, active high.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB write.
	input wire logic [7:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error.
	input wire logic [2:0] power_mode, // Chip power mode.
	input wire logic pwm_in, // PWM generator output.
	input wire logic clkdiv_in, // Timer clock-divider output.
	input wire logic [7:0] pin_in, // Pin levels.
	output logic [7:0] pin_out, // Pin drive values.
	output logic [7:0] pin_oe, // Pin output enables.
	output logic [7:0] pin_pullup, // Pull-up enables.
	output logic ext_intr_a_ff, // Interrupt A edge pulse.
	output logic ext_intr_b_ff, // Interrupt B edge pulse.
	output logic ext_intr_c_ff, // Interrupt C edge pulse.
	output logic trig_ff // Timer trigger edge pulse.
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] port_output_data_reg_ff;
	logic [7:0] port_direction_reg_ff;
	logic [7:0] pullup_enable_ff;
	logic [7:0] pin_function_select_ff;
	logic [5:0] edge_sel_ff;
	logic [2:0] pmode_ff;
	logic [31:0] nxt_prdata;
	logic wr;
	logic rd;
	logic [7:0] wbyte;
	logic [7:0] port_read;
	logic [7:0] func_is_out;
	logic [7:0] func_val;
	logic [7:0] oe_w;
	logic [7:0] out_w;
	logic [7:0] pu_w;
	logic hit_a;
	logic hit_b;
	logic hit_c;
	logic hit_t;

	function automatic logic [31:0] widen(input logic [7:0] v);
		widen = {24'h000000, v};
	endfunction : widen

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == ADDR_DATA) || (a == ADDR_DIR) ||
			(a == ADDR_PULLUP) || (a == ADDR_FUNC) ||
			(a == ADDR_EDGE) || (a == ADDR_PMODE) ||
			(a == ADDR_FLAGS);
	endfunction : mapped

	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	assign wbyte = pwdata[7:0];

	// ----------------------------------------------------------------
	// APB slave: one wait-free access phase, error on unmapped address
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped(paddr);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			port_output_data_reg_ff <= DATA_RESET;
		end else if (wr && pready && paddr == ADDR_DATA) begin
			port_output_data_reg_ff <= wbyte & PIN_MASK;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			port_direction_reg_ff <= DIR_RESET;
		end else if (wr && pready && paddr == ADDR_DIR) begin
			port_direction_reg_ff <= wbyte & PIN_MASK;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pullup_enable_ff <= PULLUP_RESET;
		end else if (wr && pready && paddr == ADDR_PULLUP) begin
			pullup_enable_ff <= wbyte & PIN_MASK;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pin_function_select_ff <= FUNC_RESET;
		end else if (wr && pready && paddr == ADDR_FUNC) begin
			// Bit 2 is forced to one, bits 3 and 1 to zero.
			pin_function_select_ff <= (wbyte & PIN_MASK) | FUNC_FIXED_ONE;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			edge_sel_ff <= EDGE_RESET;
		end else if (wr && pready && paddr == ADDR_EDGE) begin
			edge_sel_ff <= wbyte[5:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pmode_ff <= 3'h0;
		end else if (wr && pready && paddr == ADDR_PMODE) begin
			pmode_ff <= wbyte[2:0];
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	assign port_read = ((port_direction_reg_ff & port_output_data_reg_ff) |
		(~port_direction_reg_ff & pin_in)) & PIN_MASK;

	always_comb begin
		nxt_prdata = 32'h00000000;
		case (paddr)
		ADDR_DATA: nxt_prdata = widen(port_read);
		// The direction register is write-only and reads all ones.
		ADDR_DIR: nxt_prdata = widen(DIR_READ_VALUE);
		ADDR_PULLUP: nxt_prdata = widen(pullup_enable_ff);
		ADDR_FUNC: nxt_prdata = widen(pin_function_select_ff);
		ADDR_EDGE: nxt_prdata = widen({2'h0, edge_sel_ff});
		ADDR_PMODE: nxt_prdata = widen({5'h00, pmode_ff});
		ADDR_FLAGS: nxt_prdata = widen({4'h0, pin_oe[7:4]});
		default: nxt_prdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prdata <= 32'h00000000;
		end else if (rd) begin
			prdata <= nxt_prdata;
		end
	end

	// ----------------------------------------------------------------
	// Pin multiplexing
	// ----------------------------------------------------------------
	always_comb begin
		func_is_out = 8'h00;
		func_val = 8'h00;
		func_is_out[BIT_PWM] = 1'b1;
		func_is_out[BIT_CLKOUT] = 1'b1;
		func_val[BIT_PWM] = pwm_in;
		func_val[BIT_CLKOUT] = clkdiv_in;
	end

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pin
			if (PIN_MASK[g]) begin : g_cell
				pp1_pin_cell u_cell (
					.sys_clk(sys_clk),
					.reset(reset),
					.pmode(pmode_ff),
					.func_sel(pin_function_select_ff[g]),
					.func_is_out(func_is_out[g]),
					.func_val(func_val[g]),
					.dir(port_direction_reg_ff[g]),
					.data(port_output_data_reg_ff[g]),
					.pull(pullup_enable_ff[g]),
					.oe_ff(oe_w[g]),
					.out_ff(out_w[g]),
					.pu_ff(pu_w[g])
				);
			end else begin : g_none
				assign oe_w[g] = 1'b0;
				assign out_w[g] = 1'b0;
				assign pu_w[g] = 1'b0;
			end
		end
	endgenerate

	assign pin_oe = oe_w;
	assign pin_out = out_w;
	assign pin_pullup = pu_w;

	// ----------------------------------------------------------------
	// External interrupt and trigger edge detection
	// ----------------------------------------------------------------
	pp1_edge_det u_int_a (
		.sys_clk(sys_clk),
		.reset(reset),
		.enable(pin_function_select_ff[BIT_INT_A]),
		.level(pin_in[BIT_INT_A]),
		.sel(edge_sel_ff[1:0]),
		.allow_both(1'b0),
		.hit_ff(hit_a)
	);

	pp1_edge_det u_int_b (
		.sys_clk(sys_clk),
		.reset(reset),
		.enable(pin_function_select_ff[BIT_INT_B]),
		.level(pin_in[BIT_INT_B]),
		.sel(edge_sel_ff[3:2]),
		.allow_both(1'b0),
		.hit_ff(hit_b)
	);

	pp1_edge_det u_int_c (
		.sys_clk(sys_clk),
		.reset(reset),
		.enable(pin_function_select_ff[BIT_TRIG]),
		.level(pin_in[BIT_TRIG]),
		.sel({1'b0, edge_sel_ff[4]}),
		.allow_both(1'b0),
		.hit_ff(hit_c)
	);

	// The trigger shares pin 7 but has its own both-edge option.
	pp1_edge_det u_trig (
		.sys_clk(sys_clk),
		.reset(reset),
		.enable(pin_function_select_ff[BIT_TRIG]),
		.level(pin_in[BIT_TRIG]),
		.sel({edge_sel_ff[5], edge_sel_ff[4]}),
		.allow_both(1'b1),
		.hit_ff(hit_t)
	);

	assign ext_intr_a_ff = hit_a;
	assign ext_intr_b_ff = hit_b;
	assign ext_intr_c_ff = hit_c;
	assign trig_ff = hit_t;
endmodule : pp1_port

// >>> verif/pp1_port_chk.sv
`timescale 1ns/1ns
module pp1_port_chk import pp1_pkg::*; (
	input wire logic sys_clk, // Clock.
	input wire logic reset, // Reset.
	input wire logic psel, // Select.
	input wire logic penable, // Enable.
	input wire logic pwrite, // Write.
	input wire logic [7:0] paddr, // Address.
	input wire logic [31:0] pwdata, // Write data.
	input wire logic [31:0] prdata, // Read data.
	input wire logic pready, // Ready.
	input wire logic pwm_in, // PWM source.
	input wire logic clkdiv_in, // Divider source.
	input wire logic [7:0] pin_in, // Pin levels.
	input wire logic [7:0] pin_out, // Drive values.
	input wire logic [7:0] pin_oe, // Enables.
	input wire logic [7:0] pin_pullup, // Pull-ups.
	input wire logic ext_intr_a_ff // Interrupt A.
);
	// ----
	// Shadow state
	// ----
	// Pin checks need register state, so it is rebuilt from bus writes.
	logic [7:0] func_ff, dir_ff, pull_ff, edg_ff;
	logic [2:0] pm_ff;
	wire logic wr = psel && penable && pready && pwrite;
	wire logic rd = psel && penable && pready && !pwrite;
	wire logic act = pm_ff == PM_ACTIVE;
	wire logic [7:0] exp_pu = pull_ff & ~dir_ff & ~func_ff;
	wire logic [7:0] exp_oe = dir_ff & ~func_ff | func_ff & 8'h11;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			func_ff <= 8'h00;
			dir_ff <= 8'h00;
			pull_ff <= 8'h00;
			edg_ff <= 8'h00;
			pm_ff <= 3'h0;
		end else if (wr) begin
			if (paddr == ADDR_FUNC) func_ff <= pwdata[7:0] & PIN_MASK;
			if (paddr == ADDR_DIR) dir_ff <= pwdata[7:0] & PIN_MASK;
			if (paddr == ADDR_PULLUP) pull_ff <= pwdata[7:0] & PIN_MASK;
			if (paddr == ADDR_EDGE) edg_ff <= pwdata[7:0];
			if (paddr == ADDR_PMODE) pm_ff <= pwdata[2:0];
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	chk_reset_pins: assert property ($fell(reset) |->
		pin_oe == 8'h00 && pin_pullup == 8'h00) else $error("pins live");
	chk_pull_rsvd: assert property (rd && paddr == ADDR_PULLUP |->
		prdata[3:1] == 3'h0) else $error("pull-up reserved bits");
	chk_func_fixed: assert property (rd && paddr == ADDR_FUNC |->
		prdata[3:1] == 3'h2) else $error("function fixed bits");
	chk_pull_follow: assert property (act |=>
		pin_pullup == $past(exp_pu)) else $error("pull-up state");
	chk_oe_select: assert property (act |=>
		pin_oe == $past(exp_oe)) else $error("output enable");
	chk_pwm_route: assert property (act && func_ff[4] |=>
		pin_out[4] == $past(pwm_in)) else $error("pwm route");
	chk_clkdiv_route: assert property (act && func_ff[0] |=>
		pin_out[0] == $past(clkdiv_in)) else $error("divider route");
	chk_standby_float: assert property (pm_ff == PM_STANDBY |=>
		pin_oe == 8'h00) else $error("standby drive");
	chk_sleep_hold: assert property (pm_ff == PM_SLEEP |=>
		$stable(pin_out) && $stable(pin_oe)) else $error("sleep hold");
	chk_int_a_edge: assert property (act && func_ff[5] &&
		edg_ff[1:0] == EDGE_RISE && $rose(pin_in[5]) |-> ##[1:3]
		ext_intr_a_ff) else $error("interrupt A edge");
endmodule : pp1_port_chk
bind pp1_port pp1_port_chk pp1_port_chk_inst (.sys_clk, .reset, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pwm_in,
	.clkdiv_in, .pin_in, .pin_out, .pin_oe, .pin_pullup, .ext_intr_a_ff);

// >>> verif/pp1_board.sv
`timescale 1ns/1ns
module pp1_board (
	input wire logic sys_clk, // Clock.
	input wire logic [7:0] pin_out, // Port drive.
	input wire logic [7:0] pin_oe, // Port enables.
	input wire logic [7:0] pin_pullup, // Pull-ups.
	input wire logic [7:0] ext_val, // Board level.
	input wire logic [7:0] ext_drv, // Board drives.
	output logic [7:0] pin_in // Wire level.
);
	// An undriven pin without pull-up toggles, so no level can be trusted.
	logic [7:0] float_ff = 8'h5a;
	always_ff @(posedge sys_clk) begin
		float_ff <= ~float_ff;
	end
	always_comb begin
		pin_in = pin_oe & pin_out | ~pin_oe & (ext_drv & ext_val |
			~ext_drv & (pin_pullup | float_ff));
	end
endmodule : pp1_board

// >>> verif/tb_top.sv
`timescale 1ns/1ns
module tb_top import pp1_pkg::*;;
	logic sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pwm_in = 1'b0, clkdiv_in = 1'b0, pready, pslverr;
	logic [7:0] paddr = 8'h00, ext_val = 8'h00, ext_drv = 8'h00, v, eo;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [7:0] pin_in, pin_out, pin_oe, pin_pullup;
	logic ext_intr_a_ff, ext_intr_b_ff, ext_intr_c_ff, trig_ff;
	logic [40:0] q[$];
	logic [40:0] e;
	int n_errors = 0, n_tests = 0, seed = 55197, i, r;
	int na = 0, nb = 0, nc = 0, nt = 0, sa, sb, sc, st;
	pp1_port pp1_port_inst (.sys_clk, .reset, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .power_mode(3'h0),
		.pwm_in, .clkdiv_in, .pin_in, .pin_out, .pin_oe, .pin_pullup,
		.ext_intr_a_ff, .ext_intr_b_ff, .ext_intr_c_ff, .trig_ff);
	pp1_board pp1_board_inst (.sys_clk, .pin_out, .pin_oe, .pin_pullup,
		.ext_val, .ext_drv, .pin_in);
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	task chk(input string nm, input logic [32:0] x, input logic [32:0] y);
		n_tests++;
		if (y !== x) begin
			n_errors++;
			$display("wrong value %s exp %h got %h", nm, x, y);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb
	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask : wr
	task rd(input logic [7:0] a, input logic [32:0] x);
		q.push_back({a, x});
		apb(1'b0, a, 32'h0);
	endtask : rd
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			e = q.pop_front();
			chk($sformatf("addr %h", e[40:33]), e[32:0], {pslverr, prdata});
		end
		na <= na + int'(ext_intr_a_ff === 1'b1);
		nb <= nb + int'(ext_intr_b_ff === 1'b1);
		nc <= nc + int'(ext_intr_c_ff === 1'b1);
		nt <= nt + int'(trig_ff === 1'b1);
	end
	task stop_test;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		stop_test;
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		rd(ADDR_PULLUP, 33'h00);
		rd(ADDR_FUNC, 33'h04);
		rd(ADDR_DIR, 33'hff);
		for (i = 0; i < 4; i++) begin
			v = (i == 0) ? 8'hff : (i == 1) ? 8'h0e : 8'($random(seed));
			wr(ADDR_PULLUP, v);
			rd(ADDR_PULLUP, 33'(v & PIN_MASK));
			wr(ADDR_FUNC, v);
			rd(ADDR_FUNC, 33'(v & PIN_MASK | 8'h04));
		end
		$display("test registers done");
		ext_drv <= 8'hce;
		ext_val <= 8'h40;
		wr(ADDR_FUNC, 8'h00);
		wr(ADDR_DIR, 8'h30);
		wr(ADDR_DATA, 8'h20);
		wr(ADDR_PULLUP, 8'hf1);
		// Pin cells register one edge after the register write lands.
		@(posedge sys_clk);
		chk("pin_pullup", 33'hc1, 33'(pin_pullup));
		chk("pin_oe", 33'h30, 33'(pin_oe));
		rd(ADDR_DATA, 33'h61);
		$display("test direction done");
		pwm_in <= 1'b1;
		wr(ADDR_FUNC, 8'h11);
		@(posedge sys_clk);
		chk("pin_oe", 33'h31, 33'(pin_oe));
		chk("alt out", 33'h2, 33'({pin_out[4], pin_out[0]}));
		chk("pin_pullup", 33'hc0, 33'(pin_pullup));
		for (i = 0; i < 16; i++) begin
			r = $random(seed);
			pwm_in <= r[0];
			clkdiv_in <= r[1];
			@(posedge sys_clk);
		end
		$display("test alternate done");
		ext_drv <= 8'he1;
		ext_val <= 8'hc0;
		wr(ADDR_FUNC, 8'he0);
		wr(ADDR_EDGE, 8'h31);
		repeat (4) @(posedge sys_clk);
		{sa, sb, sc, st} = {na, nb, nc, nt};
		ext_val <= 8'h20;
		repeat (6) @(posedge sys_clk);
		ext_val <= 8'ha0;
		repeat (6) @(posedge sys_clk);
		chk("intr_a", 33'd1, 33'(na - sa));
		chk("intr_b", 33'd1, 33'(nb - sb));
		chk("intr_c", 33'd1, 33'(nc - sc));
		chk("trig", 33'd2, 33'(nt - st));
		$display("test edges done");
		wr(ADDR_FUNC, 8'h00);
		for (i = 0; i < 6; i++) begin
			v = i[0] ? 8'h20 : 8'h10;
			wr(ADDR_PMODE, 8'(i));
			wr(ADDR_DATA, v);
			if (i < 2) eo = v;
			@(posedge sys_clk);
			chk("pins", (i == 5) ? 33'h0 : 33'({8'h30, eo}),
				33'({pin_oe, pin_out & pin_oe}));
		end
		wr(ADDR_PMODE, 8'h00);
		$display("test power done");
		wr(8'h1c, 8'hff);
		rd(8'h1c, {1'b1, 32'h0});
		$display("test unmapped done");
		stop_test;
	end
endmodule : tb_top
